// ---- hdl/ixe_execute_unit.sv ----
// execute stage for the isa extension instructions
`timescale 1ns/1ps
`default_nettype none
module ixe_execute_unit
	import ixe_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// issued instruction and operands
	input  wire logic        ISSUE_VALID,
	input  wire logic [31:0] INSTR,
	// source operands
	input  wire logic [31:0] RS_DATA,
	input  wire logic [31:0] RT_DATA,
	// privilege and width
	input  wire logic        USER_MODE,
	input  wire logic        IS_64BIT_OP,
	// address translation answer for the prefetch
	input  wire logic        XLATE_UNCACHED,
	input  wire logic        XLATE_FAULT,
	// register file write
	output logic             RF_WE,
	output logic      [4:0]  RF_WADDR,
	output logic      [31:0] RF_WDATA,
	// exceptions
	output logic             EXC_RESERVED,
	output logic             EXC_TRAP64,
	// data cache prefetch request
	output logic             PF_REQ,
	output logic      [31:0] PF_ADDR,
	output logic      [4:0]  PF_HINT,
	output logic             PF_HOUSEKEEP,
	// accumulator
	output logic             ACC_BUSY,
	output logic      [31:0] ACC_HIGH_WORD,
	output logic      [31:0] ACC_LOW_WORD
);
	// ==========================================================
	// funct decoding shared by several controls
	function automatic logic fn_signed_mac(input logic [5:0] fn);
		return fn == FN_SMAC || fn == FN_SMSB;
	endfunction

	function automatic logic fn_sub_mac(input logic [5:0] fn);
		return fn == FN_SMSB || fn == FN_UMSB;
	endfunction

	function automatic logic fn_count(input logic [5:0] fn);
		return fn == FN_CNT_ZERO || fn == FN_CNT_ONE;
	endfunction

	// ==========================================================
	// decode
	logic [5:0]  opcode;
	logic [5:0]  funct;
	logic [4:0]  rd_f;
	logic [4:0]  rt_f;
	logic [4:0]  hint_f;
	logic        issue_ok;
	logic        wide_op;
	logic        is_special;
	logic        is_special2;
	logic        do_prefetch;
	logic        do_mov_nz;
	logic        do_mov_z;
	logic        do_mac;
	logic        do_count;
	logic        mac_signed;
	logic        mac_sub;
	logic        count_ones;
	logic [31:0] eff_addr;

	// wide ops suppress every other decode
	assign issue_ok    = ISSUE_VALID && !IS_64BIT_OP;
	assign wide_op     = ISSUE_VALID && IS_64BIT_OP;

	// ==========================================================
	// field extraction
	assign opcode      = INSTR[OPC_HI:OPC_LO];
	assign funct       = INSTR[5:0];
	assign rd_f        = INSTR[RD_LO +: 5];
	assign rt_f        = INSTR[RT_LO +: 5];
	assign hint_f      = INSTR[RT_LO +: 5];
	// ==========================================================
	// instruction class
	assign is_special  = issue_ok && opcode == OP_SPECIAL;
	assign is_special2 = issue_ok && opcode == OP_SPECIAL2;
	assign do_prefetch = issue_ok && opcode == OP_PREFETCH;
	assign do_mov_nz   = is_special && funct == FN_MOVE_NONZERO;
	assign do_mov_z    = is_special && funct == FN_MOVE_ZERO;
	assign do_mac      = is_special2 && (funct == FN_SMAC || funct == FN_UMAC ||
	                                     funct == FN_SMSB || funct == FN_UMSB);
	assign do_count    = is_special2 && fn_count(funct);
	// ==========================================================
	// accumulate and count controls
	assign mac_signed  = fn_signed_mac(funct);
	assign mac_sub     = fn_sub_mac(funct);
	assign count_ones  = funct == FN_CNT_ONE;

	// ==========================================================
	// effective address: base plus sign-extended offset
	assign eff_addr = RS_DATA + {{(32 - OFFSET_W){INSTR[OFFSET_W - 1]}},
	                             INSTR[OFFSET_W - 1:0]};

	// ==========================================================
	// prefetch qualification
	logic pf_hint_user;
	logic pf_allowed;
	logic pf_cached;
	logic pf_reserved;
	logic pf_fetch;
	logic pf_keep;
	assign pf_hint_user = USER_MODE && hint_f == HINT_IGNORE_HIT;
	assign pf_reserved  = do_prefetch && pf_hint_user;
	assign pf_allowed   = do_prefetch && !pf_reserved;
	assign pf_cached    = !XLATE_UNCACHED;
	// faults are dropped; a faulted or uncached prefetch fetches nothing
	assign pf_fetch     = pf_allowed && pf_cached && !XLATE_FAULT;
	// housekeeping only on a cached line, never on uncached space
	assign pf_keep      = pf_allowed && pf_cached && XLATE_FAULT;

	// ==========================================================
	// conditional move and counts
	logic       rt_zero;
	logic       nz_take;
	logic       z_take;
	logic       mov_take;
	logic [5:0] lead_cnt;
	assign rt_zero  = RT_DATA == 32'h0000_0000;
	assign nz_take  = do_mov_nz && !rt_zero;
	assign z_take   = do_mov_z && rt_zero;
	// only a true condition reaches the register file
	assign mov_take = nz_take || z_take;

	ixe_lead_count u_count (
		.value      (RS_DATA),
		.count_ones (count_ones),
		.count      (lead_cnt)
	);

	// ==========================================================
	// accumulate datapath
	logic mac_busy;
	logic [31:0] acc_hi;
	logic [31:0] acc_lo;

	ixe_mac u_mac (
		.clk       (CLK_SYS),
		.rst       (RST),
		.start     (do_mac),
		.is_signed (mac_signed),
		.is_sub    (mac_sub),
		.op_a      (RS_DATA),
		.op_b      (RT_DATA),
		.busy      (mac_busy),
		.done      (),
		.acc_hi    (acc_hi),
		.acc_lo    (acc_lo)
	);

	// no interlock: the outputs simply show whatever is in flight
	assign ACC_BUSY      = mac_busy;
	assign ACC_HIGH_WORD = acc_hi;
	assign ACC_LOW_WORD  = acc_lo;

	// ==========================================================
	// registered results
	logic [31:0] count_wdata;
	logic        pf_load;
	assign count_wdata = {26'h0, lead_cnt};
	// target of the last prefetch stands until the next one
	assign pf_load     = do_prefetch;

	// ==========================================================
	// register file write strobe
	logic        rf_we_d;
	logic        rf_we_q;

	assign rf_we_d = mov_take || do_count;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rf_we_q <= 1'b0;
		end else begin
			rf_we_q <= rf_we_d;
		end
	end

	// ==========================================================
	// register file write address
	logic [4:0]  rf_waddr_d;
	logic [4:0]  rf_waddr_q;

	// counts write the rt field register
	assign rf_waddr_d = do_count ? rt_f : rd_f;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rf_waddr_q <= 5'h0;
		end else begin
			rf_waddr_q <= rf_waddr_d;
		end
	end

	// ==========================================================
	// register file write data
	logic [31:0] rf_wdata_d;
	logic [31:0] rf_wdata_q;

	assign rf_wdata_d = do_count ? count_wdata : RS_DATA;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rf_wdata_q <= 32'h0;
		end else begin
			rf_wdata_q <= rf_wdata_d;
		end
	end

	// ==========================================================
	// reserved-instruction exception
	logic        exc_res_d;
	logic        exc_res_q;

	// ignore-hit hint is privileged
	assign exc_res_d = pf_reserved;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			exc_res_q <= 1'b0;
		end else begin
			exc_res_q <= exc_res_d;
		end
	end

	// ==========================================================
	// wide operation trap
	logic        exc_trap_d;
	logic        exc_trap_q;

	// wide ops trap in every mode
	assign exc_trap_d = wide_op;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			exc_trap_q <= 1'b0;
		end else begin
			exc_trap_q <= exc_trap_d;
		end
	end

	// ==========================================================
	// prefetch fetch request
	logic        pf_req_d;
	logic        pf_req_q;

	// only permitted, cached, unfaulted prefetches
	assign pf_req_d = pf_fetch;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pf_req_q <= 1'b0;
		end else begin
			pf_req_q <= pf_req_d;
		end
	end

	// ==========================================================
	// prefetch housekeeping
	logic        pf_keep_d;
	logic        pf_keep_q;

	// invisible cache action only
	assign pf_keep_d = pf_keep;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pf_keep_q <= 1'b0;
		end else begin
			pf_keep_q <= pf_keep_d;
		end
	end

	// ==========================================================
	// prefetch address
	logic [31:0] pf_addr_d;
	logic [31:0] pf_addr_q;

	assign pf_addr_d = pf_load ? eff_addr : pf_addr_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pf_addr_q <= 32'h0;
		end else begin
			pf_addr_q <= pf_addr_d;
		end
	end

	// ==========================================================
	// prefetch hint
	logic [4:0]  pf_hint_d;
	logic [4:0]  pf_hint_q;

	assign pf_hint_d = pf_load ? hint_f : pf_hint_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pf_hint_q <= 5'h0;
		end else begin
			pf_hint_q <= pf_hint_d;
		end
	end

	// ==========================================================
	// register file outputs
	assign RF_WE        = rf_we_q;
	assign RF_WADDR     = rf_waddr_q;
	assign RF_WDATA     = rf_wdata_q;

	// ==========================================================
	// exception outputs
	assign EXC_RESERVED = exc_res_q;
	assign EXC_TRAP64   = exc_trap_q;

	// ==========================================================
	// prefetch outputs
	assign PF_REQ       = pf_req_q;
	assign PF_HOUSEKEEP = pf_keep_q;
	assign PF_ADDR      = pf_addr_q;
	assign PF_HINT      = pf_hint_q;
endmodule
`default_nettype wire

// ---- hdl/ixe_lead_count.sv ----
// leading zero or one count of a 32-bit word
`timescale 1ns/1ps
`default_nettype none
module ixe_lead_count (
	// operand
	input  wire logic [31:0] value,
	input  wire logic        count_ones,
	// result
	output logic      [5:0]  count
);
	logic [31:0] scan;
	assign scan = count_ones ? ~value : value;

	// ==========================================================
	// scan from msb downward, all-clear word gives 32
	function automatic logic [5:0] lead_zeros(input logic [31:0] w);
		logic [5:0] n;
		logic       hit;
		n   = 6'h20;
		hit = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (!hit && w[i]) begin
				n   = 6'(31 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	assign count = lead_zeros(scan);
endmodule
`default_nettype wire

// ---- hdl/ixe_mac.sv ----
// multiply-accumulate datapath with 64-bit accumulator
`timescale 1ns/1ps
`default_nettype none
module ixe_mac
	import ixe_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// request
	input  wire logic        start,
	input  wire logic        is_signed,
	input  wire logic        is_sub,
	input  wire logic [31:0] op_a,
	input  wire logic [31:0] op_b,
	// accumulator
	output logic             busy,
	output logic             done,
	output logic      [31:0] acc_hi,
	output logic      [31:0] acc_lo
);
	ixe_mac_state_e state_q, state_d;
	logic [63:0] prod_q;
	logic        sub_q;
	logic [31:0] hi_q, lo_q;
	logic signed [32:0] ext_a, ext_b;
	logic signed [65:0] prod_w;
	logic [63:0] sum_w;

	// zero extension for unsigned, sign extension for signed
	assign ext_a  = {is_signed & op_a[31], op_a};
	assign ext_b  = {is_signed & op_b[31], op_b};
	assign prod_w = ext_a * ext_b;
	// wrap-around arithmetic, no overflow flagged
	assign sum_w  = sub_q ? ({hi_q, lo_q} - prod_q) : ({hi_q, lo_q} + prod_q);

	always_comb begin
		case (state_q)
			MAC_IDLE: state_d = start ? MAC_MUL : MAC_IDLE;
			MAC_MUL:  state_d = start ? MAC_MUL : MAC_ACC;
			MAC_ACC:  state_d = start ? MAC_MUL : MAC_IDLE;
			default:  state_d = MAC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= MAC_IDLE;
			prod_q  <= 64'h0;
			sub_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			if (start) begin
				prod_q <= prod_w[63:0];
				sub_q  <= is_sub;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hi_q <= ACC_RESET;
			lo_q <= ACC_RESET;
		end else if (state_q == MAC_MUL) begin
			lo_q <= sum_w[31:0];
			hi_q <= sum_w[63:32];
		end
	end

	assign busy   = (state_q == MAC_MUL);
	assign done   = (state_q == MAC_ACC);
	assign acc_hi = hi_q;
	assign acc_lo = lo_q;
endmodule
`default_nettype wire

// ---- hdl/ixe_pkg.sv ----
// constants and types shared by the isa extension execute unit
package ixe_pkg;
	// ==========================================================
	// instruction fields
	localparam logic [5:0] OP_PREFETCH   = 6'h33;
	localparam logic [5:0] OP_SPECIAL    = 6'h00;
	localparam logic [5:0] OP_SPECIAL2   = 6'h1c;
	localparam int         OPC_HI        = 31;
	localparam int         OPC_LO        = 26;
	localparam int         RS_LO         = 21;
	localparam int         RT_LO         = 16;
	localparam int         RD_LO         = 11;
	localparam int         OFFSET_W      = 16;
	// ==========================================================
	// function codes
	localparam logic [5:0] FN_MOVE_ZERO    = 6'h0a;
	localparam logic [5:0] FN_MOVE_NONZERO = 6'h0b;
	localparam logic [5:0] FN_SMAC       = 6'h00;
	localparam logic [5:0] FN_UMAC       = 6'h01;
	localparam logic [5:0] FN_SMSB       = 6'h04;
	localparam logic [5:0] FN_UMSB       = 6'h05;
	localparam logic [5:0] FN_CNT_ZERO   = 6'h20;
	localparam logic [5:0] FN_CNT_ONE    = 6'h21;
	// ==========================================================
	// hints and reset values
	localparam logic [4:0] HINT_IGNORE_HIT = 5'h19;
	localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
	localparam int         MAC_LATENCY   = 2;

	typedef enum logic [1:0] {
		MAC_IDLE = 2'b00,
		MAC_MUL  = 2'b01,
		MAC_ACC  = 2'b10
	} ixe_mac_state_e;
endpackage

// ---- testbench/ixe_core_model.sv ----
// far side: register file and data cache request count
`timescale 1ns/1ps
`default_nettype none
module ixe_core_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// requests from the unit
	input  wire logic        rf_we,
	input  wire logic [4:0]  rf_waddr,
	input  wire logic [31:0] rf_wdata,
	input  wire logic        pf_req,
	// state seen
	output logic      [15:0] pf_count_q,
	output logic      [31:0] regs_q [32]
);
	always_ff @(posedge clk) begin
		if (rst) pf_count_q <= 16'h0;
		else if (pf_req) pf_count_q <= pf_count_q + 16'h1;
		if (rf_we) regs_q[rf_waddr] <= rf_wdata;
	end
endmodule
`default_nettype wire

// ---- testbench/ixe_execute_unit_props.sv ----
// port assertions for the isa extension execute unit
`timescale 1ns/1ps
`default_nettype none
module ixe_execute_unit_props
	import ixe_pkg::*;
(
	// clock, reset and issue
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        ISSUE_VALID,
	input wire logic [31:0] INSTR,
	input wire logic [31:0] RS_DATA,
	input wire logic [31:0] RT_DATA,
	input wire logic        USER_MODE,
	input wire logic        IS_64BIT_OP,
	input wire logic        XLATE_UNCACHED,
	input wire logic        XLATE_FAULT,
	// results
	input wire logic        RF_WE,
	input wire logic [4:0]  RF_WADDR,
	input wire logic [31:0] RF_WDATA,
	input wire logic        EXC_RESERVED,
	input wire logic        EXC_TRAP64,
	input wire logic        PF_REQ,
	input wire logic [31:0] PF_ADDR,
	input wire logic [4:0]  PF_HINT,
	input wire logic        ACC_BUSY,
	input wire logic [31:0] ACC_HIGH_WORD,
	input wire logic [31:0] ACC_LOW_WORD
);
	// ==========================================================
	// decode helpers
	wire        go  = ISSUE_VALID && !IS_64BIT_OP;
	wire [4:0]  rtf = INSTR[20:16];
	wire [31:0] ea  = RS_DATA + {{16{INSTR[15]}}, INSTR[15:0]};
	wire        pf  = go && INSTR[31:26] == OP_PREFETCH;
	wire        ign = rtf == HINT_IGNORE_HIT;
	wire        s0  = go && INSTR[31:26] == OP_SPECIAL;
	wire        s2  = go && INSTR[31:26] == OP_SPECIAL2;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// ==========================================================
	// properties
	a_wide_trap: assert property (ISSUE_VALID && IS_64BIT_OP |=> EXC_TRAP64 && !RF_WE && !PF_REQ)
		else $error("wide op not trapped alone");
	a_pf_quiet: assert property (pf && !ign |=> !EXC_RESERVED && !EXC_TRAP64)
		else $error("prefetch raised an exception");
	a_pf_blocked: assert property (pf && (XLATE_UNCACHED || XLATE_FAULT) |=> !PF_REQ)
		else $error("prefetch request not blocked");
	a_pf_addr: assert property (pf && !XLATE_UNCACHED && !XLATE_FAULT && !(ign && USER_MODE)
		|=> PF_REQ && PF_ADDR == $past(ea) && PF_HINT == $past(rtf)) else $error("prefetch address wrong");
	a_move_nz: assert property (s0 && INSTR[5:0] == FN_MOVE_NONZERO
		|=> RF_WE == ($past(RT_DATA) != 0) && (!RF_WE || RF_WDATA == $past(RS_DATA)))
		else $error("move if nonzero wrong");
	a_move_z: assert property (s0 && INSTR[5:0] == FN_MOVE_ZERO
		|=> RF_WE == ($past(RT_DATA) == 0) && (!RF_WE || RF_WDATA == $past(RS_DATA)))
		else $error("move if zero wrong");
	a_clz_zero: assert property (s2 && INSTR[5:0] == FN_CNT_ZERO && RS_DATA == 0
		|=> RF_WE && RF_WDATA == 32'h20 && RF_WADDR == $past(rtf)) else $error("zero count wrong");
	a_acc_hold: assert property (!ACC_BUSY |=> $stable(ACC_HIGH_WORD) && $stable(ACC_LOW_WORD))
		else $error("accumulator moved while idle");
endmodule
`default_nettype wire

// ---- testbench/test_isa_extension_execute_unit.sv ----
// self-checking bench for the isa extension execute unit
`timescale 1ns/1ps
`default_nettype none
module test_isa_extension_execute_unit;
	import ixe_pkg::*;
	// ==========================================================
	// signals
	logic        CLK_SYS, RST, ISSUE_VALID, USER_MODE, IS_64BIT_OP, XLATE_UNCACHED, XLATE_FAULT;
	logic        RF_WE, EXC_RESERVED, EXC_TRAP64, PF_REQ, PF_HOUSEKEEP, ACC_BUSY, taken, acc_due;
	logic [4:0]  RF_WADDR, PF_HINT;
	logic [31:0] INSTR, RS_DATA, RT_DATA, RF_WDATA, PF_ADDR, ACC_HIGH_WORD, ACC_LOW_WORD, seed;
	logic [31:0] regs [32];
	logic [31:0] tbl [6] = '{32'h0, 32'h1, 32'h8000_0000, 32'hffff_ffff, 32'h0000_ffff, 32'h0};
	logic [5:0]  fns [4] = '{FN_SMAC, FN_UMAC, FN_SMSB, FN_UMSB};
	logic [63:0] acc, accs[$];
	logic [78:0] note, seen, notes[$];
	logic [15:0] pf_count;
	int          n_errors, num_checks, n_pf;
	ixe_execute_unit uut (.*);
	ixe_core_model far (.clk(CLK_SYS), .rst(RST), .rf_we(RF_WE), .rf_waddr(RF_WADDR),
		.rf_wdata(RF_WDATA), .pf_req(PF_REQ), .pf_count_q(pf_count), .regs_q(regs));
	assign seen = {RF_WE, RF_WE ? {RF_WADDR, RF_WDATA} : 37'h0, EXC_RESERVED, EXC_TRAP64,
		PF_REQ, PF_HOUSEKEEP, PF_REQ ? {PF_ADDR, PF_HINT} : 37'h0};
	// ==========================================================
	// helpers
	task automatic check(string what, logic [78:0] got, logic [78:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [31:0] sp(logic [5:0] op, logic [4:0] r, logic [5:0] fn);
		return {op, 5'h1, r, r, 5'h0, fn};
	endfunction
	function automatic logic [78:0] wr(logic [4:0] a, logic [31:0] d);
		return {1'b1, a, d, 41'h0};
	endfunction
	function automatic logic [78:0] pfx(logic [31:0] a, logic [4:0] h);
		return {40'h0, 2'b10, a, h};
	endfunction
	function automatic logic [31:0] lead(logic [31:0] v, logic ones);
		lead = 32'h0;
		for (int i = 31; i >= 0 && v[i] == ones; i--) lead++;
	endfunction
	// flags are {user, wide, uncached, fault}
	task automatic issue(logic [31:0] ins, logic [31:0] rs, logic [31:0] rt, logic [3:0] fl,
		logic [78:0] e);
		@(posedge CLK_SYS);
		ISSUE_VALID <= 1'b1;
		INSTR <= ins;
		RS_DATA <= rs;
		RT_DATA <= rt;
		{USER_MODE, IS_64BIT_OP, XLATE_UNCACHED, XLATE_FAULT} <= fl;
		notes.push_back(e);
		n_pf += int'(e[38]);
	endtask
	task automatic mac(logic [5:0] fn, logic [31:0] a, logic [31:0] b);
		logic [63:0] p;
		logic [31:0] r;
		p = {32'h0, a} * {32'h0, b};
		if (fn == FN_SMAC || fn == FN_SMSB) p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		acc = (fn == FN_SMSB || fn == FN_UMSB) ? acc - p : acc + p;
		accs.push_back(acc);
		r = rnd();
		issue(sp(OP_SPECIAL2, 5'h2, fn), a, b, {r[0], 3'h0}, 79'h0);
	endtask
	// ==========================================================
	// result monitor
	always @(posedge CLK_SYS) taken <= ISSUE_VALID && !RST;
	always @(negedge CLK_SYS) begin
		if (taken) begin
			note = notes.pop_front();
			check("regfile write", 79'(seen[78:41]), 79'(note[78:41]));
			check("exception", 79'(seen[40:39]), 79'(note[40:39]));
			check("prefetch", 79'(seen[38:0]), 79'(note[38:0]));
		end
		if (acc_due) check("accumulator", 79'({ACC_HIGH_WORD, ACC_LOW_WORD}), 79'(accs.pop_front()));
		acc_due = ACC_BUSY === 1'b1;
	end
	// ==========================================================
	// clock, watchdog and sequence
	initial begin
		CLK_SYS = 1'b0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		n_errors++;
		wrap_up();
	end
	initial begin
		logic [31:0] v, w;
		{RST, ISSUE_VALID, USER_MODE, IS_64BIT_OP, XLATE_UNCACHED, XLATE_FAULT} = 6'b100000;
		{INSTR, RS_DATA, RT_DATA} = 96'h0;
		seed = 32'h35b2aeb3;
		acc = 64'h0;
		repeat (10) @(posedge CLK_SYS);
		RST <= 1'b0;
		issue(sp(OP_SPECIAL, 5'h3, FN_MOVE_NONZERO), 32'h1234_5678, 32'h8000_0000, 4'h0,
			wr(5'h3, 32'h1234_5678));
		issue(sp(OP_SPECIAL, 5'h3, FN_MOVE_NONZERO), 32'h0bad_0bad, 32'h0, 4'h3, 79'h0);
		issue(sp(OP_SPECIAL, 5'h4, FN_MOVE_ZERO), 32'hdead_beef, 32'h0, 4'h0,
			wr(5'h4, 32'hdead_beef));
		issue(sp(OP_SPECIAL, 5'h3, FN_MOVE_ZERO), 32'h0bad_0bad, 32'h1, 4'h8, 79'h0);
		for (int i = 0; i < 12; i++) begin
			v = (i % 6 == 5) ? rnd() : tbl[i % 6];
			w = rnd();
			issue(sp(OP_SPECIAL2, 5'(i + 8), i < 6 ? FN_CNT_ZERO : FN_CNT_ONE), v, rnd(),
				{w[2], 1'b0, w[1:0]}, wr(5'(i + 8), lead(v, i >= 6)));
		end
		for (int i = 0; i < 9; i++) mac(fns[i % 4], i == 0 ? 32'hffff_fffe : rnd(), rnd());
		issue(sp(OP_SPECIAL2, 5'h6, 6'h3f), 32'h5, 32'h5, 4'h0, 79'h0);
		v = 32'h0000_1000;
		issue({OP_PREFETCH, 5'h1, 5'h0, 16'hfff0}, v, rnd(), 4'h0, pfx(32'h0ff0, 5'h0));
		issue({OP_PREFETCH, 5'h1, 5'h4, 16'h7fff}, v, rnd(), 4'h2, 79'h0);
		issue({OP_PREFETCH, 5'h1, 5'h4, 16'h0010}, v, rnd(), 4'h1, 79'(1) << 37);
		issue({OP_PREFETCH, 5'h1, 5'h4, 16'h0010}, v, rnd(), 4'h3, 79'h0);
		issue({OP_PREFETCH, 5'h1, HINT_IGNORE_HIT, 16'h8000}, v, rnd(), 4'h8, 79'(1) << 40);
		issue({OP_PREFETCH, 5'h1, HINT_IGNORE_HIT, 16'h8000}, v, rnd(), 4'h0,
			pfx(32'hffff_9000, HINT_IGNORE_HIT));
		issue(sp(OP_SPECIAL, 5'h5, FN_MOVE_ZERO), 32'h1, 32'h0, 4'hc, 79'(1) << 39);
		issue({OP_PREFETCH, 26'h0}, v, 32'h0, 4'h4, 79'(1) << 39);
		@(posedge CLK_SYS);
		ISSUE_VALID <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		check("prefetch count", 79'(pf_count), 79'(n_pf));
		check("kept target", 79'(regs[3]), 79'(32'h1234_5678));
		check("left notes", 79'(notes.size() + accs.size()), 79'h0);
		wrap_up();
	end
endmodule
bind ixe_execute_unit ixe_execute_unit_props chk (.*);
`default_nettype wire
